// [rset_pkg.sv]
// Package of constants and carrier types for the dual resistor setting command unit
// How it works
// - Each 10-bit setting decodes to a one-hot select over 1024 taps.
// - Exactly one tap switch is on; the common terminal switch stays on; reset turns all of them off.
// - Code zero selects the bottom tap; each code step moves one tap up.
// - Opcode B, address 0 loads low 10 data bits into first setting.
// - Address bit 0 picks the channel; opcode B address 1 loads second setting.
// - Serial output shifts out the command word of the last whole 24-bit frame; short frames are not echoed.
// - Opcode E, address 0 adds one to the first setting, holding at 3FF.
// - Opcode 2, address 0 saves the first setting into slot one.
// - Saves are refused while the store lock pin is low.
// - Opcode 1, address 0 restores slot one into the first setting.
// - Restore activity stays raised after opcode 1 until opcode 0 runs.
// - Opcode 8 restores both slots into both settings, fields ignored.
// - Both settings reload from slots at reset and on recall strobe.
// - Opcode C doubles the addressed channel's setting by a left shift, saturating to 3FF when bit 9 is set.
// - Frames are 24 bits MSB first: opcode, address, 16 data bits.
// - The open-drain serial output is released while chip select is high.
// - Command executes when chip select returns high after a frame.
// - Slave works in clock polarity/phase 0/0 and 1/1 modes.
package rset_pkg;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int OP_MSB = 23;
  localparam int OP_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int SET_BITS = 10;
  localparam int TAPS = 1024;
  localparam int CNT_BITS = 5;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_RESTORE = 4'h1;
  localparam logic [3:0] OP_SAVE = 4'h2;
  localparam logic [3:0] OP_RESTORE_ALL = 4'h8;
  localparam logic [3:0] OP_LOAD = 4'hB;
  localparam logic [3:0] OP_SHIFT_LEFT = 4'hC;
  localparam logic [3:0] OP_INCREMENT = 4'hE;
  // ----------------------------------------
  // Reset and full-scale values
  // ----------------------------------------
  localparam logic [9:0] SLOT_RESET = 10'h200;
  localparam logic [9:0] SET_FULL = 10'h3FF;

  typedef struct packed {
    logic [3:0] op;
    logic [3:0] addr;
    logic [15:0] data;
  } cmd_word_s;

  typedef struct packed {
    logic [9:0] first;
    logic [9:0] second;
  } setting_pair_s;
endpackage : rset_pkg

// [tap_decoder.sv]
// One-hot tap switch decoder for one resistor setting
`timescale 1ns/100ps
`default_nettype none
module tap_decoder
  import rset_pkg::*;
#(
  parameter int W = SET_BITS
)(
  input wire logic clock, // System clock
  input wire logic resetn, // Sync reset, active low
  input wire logic [W-1:0] setting, // Resistor setting
  output logic [(1<<W)-1:0] tap_switch, // One-hot tap select
  output logic common_terminal_switch // On except while in reset
);
  typedef struct packed {
    logic [(1<<W)-1:0] tap;
    logic common;
  } dec_state_s;

  dec_state_s st_r, st_nxt;
  logic [(1<<W)-1:0] onehot;

  genvar i;
  generate
    for (i = 0; i < (1<<W); i++)
    begin : g_tap
      assign onehot[i] = (setting == W'(i));
    end
  endgenerate

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tap = onehot;
    st_nxt.common = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tap_switch = st_r.tap;
  assign common_terminal_switch = st_r.common;
endmodule : tap_decoder
`default_nettype wire

// [rset_cmd_unit.sv]
// Serial command interpreter for two resistor settings with nonvolatile slots
`timescale 1ns/100ps
`default_nettype none
module rset_cmd_unit
  import rset_pkg::*;
(
  input wire logic clock, // 50 MHz system clock
  input wire logic resetn, // Sync reset, active low (power-on)
  input wire logic sclk, // Serial clock from host
  input wire logic cs_n, // Chip select, active low
  input wire logic sdi, // Serial data in
  output logic sdo_o, // Serial data out level (always 0, open drain)
  output logic sdo_oe_n, // Serial out enable, low while pulling
  input wire logic store_lock_n, // Save lock, active low
  input wire logic recall_strobe_pin_n, // Recall strobe, active low
  output logic restore_active, // Elevated restore activity state
  output logic [9:0] first_resistor_setting, // Setting one
  output logic [9:0] second_resistor_setting, // Setting two
  output logic [9:0] nonvolatile_slot_one, // Stored slot one
  output logic [9:0] nonvolatile_slot_two, // Stored slot two
  output logic [TAPS-1:0] tap_switch_one, // Tap selects channel one
  output logic [TAPS-1:0] tap_switch_two, // Tap selects channel two
  output logic common_terminal_switch_one, // Common switch channel one
  output logic common_terminal_switch_two // Common switch channel two
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {ST_BOOT = 2'b00, ST_RUN = 2'b01} mode_e;

  // All state in one record so reset and next state stay in step
  typedef struct packed {
    mode_e mode;
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [2:0] lock_s;
    logic [2:0] rcl_s;
    logic [2:0] sdi_s;
    logic [CNT_BITS-1:0] cnt;
    cmd_word_s shift_in;
    logic [FRAME_BITS-1:0] shift_out;
    logic [FRAME_BITS-1:0] last_cmd;
    setting_pair_s set;
    setting_pair_s slot;
    logic restore;
    logic sdo_oe_n;
  } state_s;

  state_s st_r, st_nxt;

  logic sclk_rise, sclk_fall, cs_fall, cs_rise, cs_low, rcl_fall, lock_low;
  logic samp_edge, shift_edge;
  logic sel;
  logic [9:0] cur, cur_inc, cur_dbl;
  cmd_word_s cmd;

  // ----------------------------------------
  // Settled pin edges
  // ----------------------------------------
  // A difference between stages 2 and 3 marks a settled change
  assign sclk_rise = st_r.sclk_s[1] & ~st_r.sclk_s[2];
  assign sclk_fall = ~st_r.sclk_s[1] & st_r.sclk_s[2];
  assign cs_fall = ~st_r.cs_s[1] & st_r.cs_s[2];
  assign cs_rise = st_r.cs_s[1] & ~st_r.cs_s[2];
  assign cs_low = ~st_r.cs_s[2];
  assign rcl_fall = ~st_r.rcl_s[1] & st_r.rcl_s[2];
  assign lock_low = ~st_r.lock_s[2];
  // Both modes sample on rising and shift on falling
  assign samp_edge = sclk_rise;
  assign shift_edge = sclk_fall;
  assign cmd = st_r.shift_in;
  assign sel = cmd.addr[0];
  assign cur = sel ? st_r.set.second : st_r.set.first;
  // Saturate rather than wrap, so a tap never jumps end to end
  assign cur_inc = (cur == SET_FULL) ? cur : cur + 10'h001;
  assign cur_dbl = cur[9] ? SET_FULL : {cur[8:0], 1'b0};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sclk_s = {st_r.sclk_s[1:0], sclk};
    st_nxt.cs_s = {st_r.cs_s[1:0], cs_n};
    st_nxt.lock_s = {st_r.lock_s[1:0], store_lock_n};
    st_nxt.rcl_s = {st_r.rcl_s[1:0], recall_strobe_pin_n};
    st_nxt.sdi_s = {st_r.sdi_s[1:0], sdi};
    case (st_r.mode)
      ST_BOOT:
      begin
        // Power-on load of both settings from the slots
        st_nxt.set = st_r.slot;
        st_nxt.mode = ST_RUN;
      end
      ST_RUN:
      begin
        if (cs_fall)
        begin
          // Mode 1/1 has an extra leading fall; a zero count skips it
          st_nxt.cnt = '0;
          st_nxt.shift_out = st_r.last_cmd;
        end
        else if (cs_low)
        begin
          if (samp_edge && st_r.cnt != CNT_BITS'(FRAME_BITS))
          begin
            st_nxt.shift_in = {st_r.shift_in[FRAME_BITS-2:0], st_r.sdi_s[2]};
            st_nxt.cnt = st_r.cnt + CNT_BITS'(1);
          end
          if (shift_edge && st_r.cnt != '0)
            st_nxt.shift_out = {st_r.shift_out[FRAME_BITS-2:0], 1'b1};
        end
        // Only whole frames execute or update the echo word
        if (cs_rise && st_r.cnt == CNT_BITS'(FRAME_BITS))
        begin
          st_nxt.last_cmd = cmd;
          case (cmd.op)
            OP_NOP: st_nxt.restore = 1'b0;
            OP_LOAD:
            begin
              if (sel)
                st_nxt.set.second = cmd.data[9:0];
              else
                st_nxt.set.first = cmd.data[9:0];
            end
            OP_INCREMENT:
            begin
              if (sel)
                st_nxt.set.second = cur_inc;
              else
                st_nxt.set.first = cur_inc;
            end
            OP_SHIFT_LEFT:
            begin
              if (sel)
                st_nxt.set.second = cur_dbl;
              else
                st_nxt.set.first = cur_dbl;
            end
            // A locked save is still echoed, only the slot write is dropped
            OP_SAVE:
            begin
              if (!lock_low)
              begin
                if (sel)
                  st_nxt.slot.second = cur;
                else
                  st_nxt.slot.first = cur;
              end
            end
            OP_RESTORE:
            begin
              if (sel)
                st_nxt.set.second = st_r.slot.second;
              else
                st_nxt.set.first = st_r.slot.first;
              st_nxt.restore = 1'b1;
            end
            OP_RESTORE_ALL: st_nxt.set = st_r.slot;
            default: ;
          endcase
        end
        // Placed last so a recall overrides a command in the same cycle
        if (rcl_fall)
          st_nxt.set = st_r.slot;
      end
      default: st_nxt.mode = ST_BOOT;
    endcase
    // Pull low only for a 0 bit while selected; high comes from the pull-up
    st_nxt.sdo_oe_n = st_nxt.cs_s[2] | st_nxt.shift_out[FRAME_BITS-1];
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      st_r <= '0;
      st_r.mode <= ST_BOOT;
      st_r.sclk_s <= 3'h0;
      st_r.cs_s <= 3'h7;
      st_r.lock_s <= 3'h7;
      st_r.rcl_s <= 3'h7;
      st_r.slot <= {SLOT_RESET, SLOT_RESET}; // Slots keep values across reset only in silicon
      st_r.sdo_oe_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open drain: only the enable moves, the level stays low
  assign sdo_o = 1'b0;
  assign sdo_oe_n = st_r.sdo_oe_n;
  assign restore_active = st_r.restore;
  assign first_resistor_setting = st_r.set.first;
  assign second_resistor_setting = st_r.set.second;
  assign nonvolatile_slot_one = st_r.slot.first;
  assign nonvolatile_slot_two = st_r.slot.second;

  // ----------------------------------------
  // Tap decoders
  // ----------------------------------------
  tap_decoder #(.W(SET_BITS)) u_dec_one (
    .clock(clock),
    .resetn(resetn),
    .setting(st_r.set.first),
    .tap_switch(tap_switch_one),
    .common_terminal_switch(common_terminal_switch_one)
  );

  tap_decoder #(.W(SET_BITS)) u_dec_two (
    .clock(clock),
    .resetn(resetn),
    .setting(st_r.set.second),
    .tap_switch(tap_switch_two),
    .common_terminal_switch(common_terminal_switch_two)
  );
endmodule : rset_cmd_unit
`default_nettype wire

// [rset_cmd_unit_props.sv]
// Port-level checks for the resistor setting command unit
`timescale 1ns/100ps
`default_nettype none
module rset_cmd_unit_props
  import rset_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic resetn, // Reset
  input wire logic cs_n, // Select
  input wire logic sdo_oe_n, // Enable
  input wire logic store_lock_n, // Lock
  input wire logic recall_strobe_pin_n, // Recall
  input wire logic restore_active, // Restore
  input wire logic [9:0] first_resistor_setting, // Setting
  input wire logic [9:0] nonvolatile_slot_one, // Slot
  input wire logic [TAPS-1:0] tap_switch_one, // Taps
  input wire logic common_terminal_switch_one // Common
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Margins cover the three-flop input sync
  chk_oe_idle: assert property (cs_n [*6] |-> sdo_oe_n)
    else $error("out not released");
  chk_tap_single: assert property (resetn [*4] |-> $onehot(tap_switch_one))
    else $error("taps not one-hot");
  chk_tap_code: assert property (resetn [*4] |-> tap_switch_one[$past(first_resistor_setting)])
    else $error("wrong tap");
  chk_common_on: assert property (resetn [*3] |-> common_terminal_switch_one)
    else $error("common off");
  chk_lock_save: assert property ((!store_lock_n) [*4] |=> $stable(nonvolatile_slot_one))
    else $error("save while locked");
  // Chip select idle cycles, saturating; stands in for a long repetition
  logic [3:0] idle_cnt_r;
  always_ff @(posedge clock)
  begin
    if (!resetn || !cs_n)
      idle_cnt_r <= 4'h0;
    else if (idle_cnt_r != 4'hF)
      idle_cnt_r <= idle_cnt_r + 4'h1;
  end
  chk_restore_hold: assert property (cs_n && idle_cnt_r >= 4'h8 && restore_active
    |=> restore_active) else $error("restore dropped");
  chk_recall_load: assert property ($fell(recall_strobe_pin_n) |-> ##[1:8]
    first_resistor_setting == nonvolatile_slot_one) else $error("recall missed");
  chk_reset_load: assert property ($rose(resetn) |-> ##[1:2]
    first_resistor_setting == nonvolatile_slot_one) else $error("reset load missed");
  chk_frame_hold: assert property ((!cs_n) [*8] |=> $stable(first_resistor_setting))
    else $error("setting moved in frame");
  cover property ($rose(restore_active));
  cover property ($fell(recall_strobe_pin_n));
  cover property (!store_lock_n && !cs_n);
endmodule : rset_cmd_unit_props
bind rset_cmd_unit rset_cmd_unit_props u_props (.clock, .resetn, .cs_n, .sdo_oe_n,
  .store_lock_n, .recall_strobe_pin_n, .restore_active, .first_resistor_setting,
  .nonvolatile_slot_one, .tap_switch_one, .common_terminal_switch_one);
`default_nettype wire

// [rset_host_model.sv]
// Serial host model framing commands for the command unit
`timescale 1ns/100ps
`default_nettype none
module rset_host_model (
  input wire logic clock, // Clock
  input wire logic sdo_line, // Echo line
  output logic sclk, // Link clock
  output logic cs_n, // Select
  output logic sdi // Data
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Echo read late in the high phase, well after the shift
  task automatic xfer(input logic [23:0] w, input logic cpol, input int n,
                      output logic [23:0] e);
    sclk <= cpol;
    @(posedge clock);
    cs_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 23; i > 23 - n; i--)
    begin
      sclk <= 1'b0;
      sdi <= w[i];
      repeat (4) @(posedge clock);
      sclk <= 1'b1;
      repeat (4) @(posedge clock);
      e[i] = sdo_line;
    end
    sclk <= cpol;
    repeat (4) @(posedge clock);
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (10) @(posedge clock);
  endtask : xfer
endmodule : rset_host_model
`default_nettype wire

// [rset_cmd_unit_bench.sv]
// Self-checking bench of the resistor setting command unit
`timescale 1ns/100ps
`default_nettype none
module rset_cmd_unit_bench
  import rset_pkg::*;
;
  typedef struct packed {logic [23:0] w; logic [3:0] m; logic [11:0] f, s;} row_s;
  // Frame, clock mode, expected first and second setting
  row_s rows [12] = '{52'hB00100_0_100_200, 52'hB10155_1_100_155, 52'hE0FFFF_1_101_155,
    52'hE00000_0_102_155, 52'hC00000_0_204_155, 52'hC10000_1_204_2AA, 52'hB003FF_0_3FF_2AA,
    52'hE00000_1_3FF_2AA, 52'hB10300_0_3FF_300, 52'hC10000_1_3FF_3FF, 52'hB00123_0_123_3FF,
    52'h200000_1_123_3FF};
  logic clock, resetn, store_lock_n, recall_strobe_pin_n, restore_active, sdo_o, sdo_oe_n;
  logic sclk, cs_n, sdi, c1, c2;
  logic [9:0] set1, set2, slot1, slot2;
  logic [TAPS-1:0] tap1, tap2;
  logic [23:0] echo;
  int num_errors = 0;
  int cmp_count = 0;
  wire logic sdo_line = sdo_oe_n ? 1'b1 : sdo_o; // Pull-up
  rset_cmd_unit DUT (.clock, .resetn, .sclk, .cs_n, .sdi, .sdo_o, .sdo_oe_n, .store_lock_n,
    .recall_strobe_pin_n, .restore_active, .first_resistor_setting(set1),
    .second_resistor_setting(set2), .nonvolatile_slot_one(slot1), .nonvolatile_slot_two(slot2),
    .tap_switch_one(tap1), .tap_switch_two(tap2), .common_terminal_switch_one(c1),
    .common_terminal_switch_two(c2));
  rset_host_model HOST (.clock, .sdo_line, .sclk, .cs_n, .sdi);
  task automatic cmp_word(input string nm, input logic [23:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word
  task automatic check_setting(input logic [11:0] e1, e2);
    cmp_word("settings", {e1, e2}, {2'h0, set1, 2'h0, set2});
    cmp_word("taps", 24'h7, {21'h0, c1 & c2, $onehot(tap1) & tap1[e1[9:0]],
      $onehot(tap2) & tap2[e2[9:0]]});
  endtask : check_setting
  task automatic complete_run;
    $display("errors %0d of %0d compares", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    complete_run();
  end
  initial
  begin
    resetn = 1'b0;
    store_lock_n = 1'b1;
    recall_strobe_pin_n = 1'b1;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (6) @(posedge clock);
    foreach (rows[i])
    begin
      HOST.xfer(rows[i].w, rows[i].m[0], 24, echo);
      check_setting(rows[i].f, rows[i].s);
      if (i > 0)
        cmp_word("echo", rows[i - 1].w, echo);
    end
    store_lock_n <= 1'b0;
    HOST.xfer(24'hB00055, 1'b0, 24, echo);
    HOST.xfer(24'h200000, 1'b0, 24, echo);
    cmp_word("slot", 24'h123, 24'(slot1));
    store_lock_n <= 1'b1;
    HOST.xfer(24'hB00077, 1'b1, 16, echo);
    check_setting(12'h055, 12'h3FF);
    HOST.xfer(24'h100000, 1'b1, 24, echo);
    cmp_word("echo", 24'h200000, echo);
    cmp_word("restore", {13'h0, 1'b1, 10'h123}, {13'h0, restore_active, set1});
    HOST.xfer(24'h000000, 1'b0, 24, echo);
    cmp_word("restore", 24'h0, 24'(restore_active));
    HOST.xfer(24'h8FFFFF, 1'b1, 24, echo);
    check_setting(12'h123, 12'h200);
    HOST.xfer(24'hB00000, 1'b0, 24, echo);
    recall_strobe_pin_n <= 1'b0;
    repeat (4) @(posedge clock);
    recall_strobe_pin_n <= 1'b1;
    repeat (10) @(posedge clock);
    check_setting(12'h123, 12'h200);
    HOST.xfer(24'hB10066, 1'b1, 24, echo);
    HOST.xfer(24'h210000, 1'b0, 24, echo);
    cmp_word("slot two", 24'h066, 24'(slot2));
    HOST.xfer(24'hB10000, 1'b1, 24, echo);
    HOST.xfer(24'h110000, 1'b0, 24, echo);
    check_setting(12'h123, 12'h066);
    cmp_word("echo", 24'hB10000, echo);
    HOST.xfer(24'h000000, 1'b1, 24, echo);
    cmp_word("restore", 24'h0, 24'(restore_active));
    resetn <= 1'b0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (6) @(posedge clock);
    check_setting(12'h200, 12'h200);
    complete_run();
  end
endmodule : rset_cmd_unit_bench
`default_nettype wire
